// ### pkg/drr_pkg.sv
// Overview of operation
// - Each of the seven first-controller channels ORs its assigned request lines.
// - Each of the five second-controller channels ORs its assigned request lines.
// - Relocate bit clear: advanced-timer captures one/two go to first channels 2/3.
// - Relocate bit set: both advanced-timer capture requests go to first channel 6.
// - High density: converter requests go first 3/4 when set, second 3/4 when clear.
// - Low/medium density: converter requests always go to first channels 3 and 4.
// - First-controller channels 1, 5 and 7 have a fixed source set; channels 2, 3, 4 and 6 follow the relocate bits.
// - Second-controller channels 1, 2 and 5 have a fixed source set; channels 3 and 4 follow the converter relocate bit.
// - Second controller and its routing exist only in the high-density variant.
// - Second controller has only five channels; channels six and seven do nothing.
// - Controller registers take byte, halfword and word accesses.
package drr_pkg;

    // Device variants
    typedef enum logic [0:0] {
        DRR_LOW_MEDIUM_DENSITY = 1'h0,
        DRR_HIGH_DENSITY = 1'h1
    } drr_variant_e;

    // Channel counts of the two controllers
    localparam int unsigned DRR_FIRST_CHANNELS = 7;
    localparam int unsigned DRR_SECOND_CHANNELS = 5;

    // OR input width of each first-controller channel; channels 2 and 6 include one input tied low
    localparam int unsigned DRR_F1_SRC = 3;
    localparam int unsigned DRR_F2_SRC = 6;
    localparam int unsigned DRR_F3_SRC = 6;
    localparam int unsigned DRR_F4_SRC = 8;
    localparam int unsigned DRR_F5_SRC = 10;
    localparam int unsigned DRR_F6_SRC = 9;
    localparam int unsigned DRR_F7_SRC = 7;

    // Number of request lines feeding each second-controller channel
    localparam int unsigned DRR_S1_SRC = 4;
    localparam int unsigned DRR_S2_SRC = 3;
    localparam int unsigned DRR_S3_SRC = 2;
    localparam int unsigned DRR_S4_SRC = 3;
    localparam int unsigned DRR_S5_SRC = 2;

endpackage : drr_pkg

// ### rtl/drr_req_or.sv
// OR of all request lines assigned to one channel
module drr_req_or #(
    parameter int unsigned WIDTH = 2
) (
    // Source request levels
    input wire logic [WIDTH-1:0] srcReq,
    // Combined channel request
    output logic chanReq
);
    // No storage: request reaches the channel in the same cycle
    assign chanReq = |srcReq;
endmodule : drr_req_or

// ### rtl/dma_request_router.sv
module dma_request_router #(
    parameter drr_pkg::drr_variant_e VARIANT = drr_pkg::DRR_HIGH_DENSITY
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Relocation bits from the pin function unit
    input wire logic advTimerRequestRelocate,
    input wire logic basicTimerConverterRelocate,
    // Analog converter
    input wire logic analogConverterReq,
    // Serial peripheral interfaces
    input wire logic serialOneRxReq,
    input wire logic serialOneTxReq,
    input wire logic serialTwoRxReq,
    input wire logic serialTwoTxReq,
    input wire logic serialThreeRxReq,
    input wire logic serialThreeTxReq,
    // Synchronous/asynchronous serial units
    input wire logic usartOneTxReq,
    input wire logic usartOneRxReq,
    input wire logic usartTwoTxReq,
    input wire logic usartTwoRxReq,
    input wire logic usartThreeTxReq,
    input wire logic usartThreeRxReq,
    input wire logic fourthUartTransmitReq,
    input wire logic fourthUartReceiveReq,
    input wire logic fifthUartTransmitReq,
    input wire logic fifthUartReceiveReq,
    // Two-wire bus units
    input wire logic twoWireOneTxReq,
    input wire logic twoWireOneRxReq,
    input wire logic twoWireTwoTxReq,
    input wire logic twoWireTwoRxReq,
    // Advanced timer
    input wire logic advTimerCaptureOneReq,
    input wire logic advTimerCaptureTwoReq,
    input wire logic advTimerCaptureThreeReq,
    input wire logic advTimerCaptureFourReq,
    input wire logic advTimerTriggerReq,
    input wire logic advTimerCommutationReq,
    input wire logic advTimerUpdateReq,
    // General timer two
    input wire logic gpTimerTwoCaptureOneReq,
    input wire logic gpTimerTwoCaptureTwoReq,
    input wire logic gpTimerTwoCaptureThreeReq,
    input wire logic gpTimerTwoCaptureFourReq,
    input wire logic gpTimerTwoUpdateReq,
    // General timer three
    input wire logic gpTimerThreeCaptureOneReq,
    input wire logic gpTimerThreeCaptureThreeReq,
    input wire logic gpTimerThreeCaptureFourReq,
    input wire logic gpTimerThreeUpdateReq,
    input wire logic gpTimerThreeTriggerReq,
    // General timer four
    input wire logic gpTimerFourCaptureOneReq,
    input wire logic gpTimerFourCaptureTwoReq,
    input wire logic gpTimerFourCaptureThreeReq,
    input wire logic gpTimerFourUpdateReq,
    // Timer five
    input wire logic timerFiveCaptureOneReq,
    input wire logic timerFiveCaptureTwoReq,
    input wire logic timerFiveCaptureThreeReq,
    input wire logic timerFiveCaptureFourReq,
    input wire logic timerFiveUpdateReq,
    input wire logic timerFiveTriggerReq,
    // Basic timers shared with converter channels
    input wire logic basicTimerConverterOneReq,
    input wire logic basicTimerConverterTwoReq,
    // Small timer fifteen
    input wire logic smallTimerFifteenCaptureOneReq,
    input wire logic smallTimerFifteenUpdateReq,
    input wire logic smallTimerFifteenTriggerReq,
    input wire logic smallTimerFifteenCommutationReq,
    // Small timers sixteen and seventeen
    input wire logic smallTimerSixteenCaptureOneReq,
    input wire logic smallTimerSixteenUpdateReq,
    input wire logic smallTimerSeventeenCaptureOneReq,
    input wire logic smallTimerSeventeenUpdateReq,
    // Channel requests, bit 0 is channel 1
    output logic [drr_pkg::DRR_FIRST_CHANNELS-1:0] firstChanReq,
    output logic [drr_pkg::DRR_SECOND_CHANNELS-1:0] secondChanReq
);
    import drr_pkg::*;

    logic rstMeta;
    logic rstSyncN;
    logic hasSecond;
    logic advToSix;
    logic advCapOneLow;
    logic advCapTwoLow;
    logic advCapHigh;
    logic convToFirst;
    logic convOneFirst;
    logic convTwoFirst;
    logic convOneSecond;
    logic convTwoSecond;
    logic [DRR_SECOND_CHANNELS-1:0] secondRaw;

    // Reset release through two flops; only the checks below use it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Variant decides whether the second controller is present
    assign hasSecond = (VARIANT == DRR_HIGH_DENSITY);

    // Advanced timer capture steering
    assign advToSix = advTimerRequestRelocate;
    assign advCapOneLow = advTimerCaptureOneReq & ~advToSix;
    assign advCapTwoLow = advTimerCaptureTwoReq & ~advToSix;
    assign advCapHigh = (advTimerCaptureOneReq | advTimerCaptureTwoReq) & advToSix;

    // Converter steering; smaller variants ignore the relocate bit
    assign convToFirst = ~hasSecond | basicTimerConverterRelocate;
    assign convOneFirst = basicTimerConverterOneReq & convToFirst;
    assign convTwoFirst = basicTimerConverterTwoReq & convToFirst;
    assign convOneSecond = basicTimerConverterOneReq & ~convToFirst;
    assign convTwoSecond = basicTimerConverterTwoReq & ~convToFirst;

    // First controller channels; the OR cannot separate two live sources,
    // so software keeps one source enabled per channel
    drr_req_or #(.WIDTH(DRR_F1_SRC)) uFirst1 (
        .srcReq({analogConverterReq, gpTimerTwoCaptureThreeReq, gpTimerFourCaptureOneReq}),
        .chanReq(firstChanReq[0])
    );
    drr_req_or #(.WIDTH(DRR_F2_SRC)) uFirst2 (
        .srcReq({serialOneRxReq, usartThreeTxReq, advCapOneLow, gpTimerTwoUpdateReq,
                 gpTimerThreeCaptureThreeReq, 1'b0}),
        .chanReq(firstChanReq[1])
    );
    drr_req_or #(.WIDTH(DRR_F3_SRC)) uFirst3 (
        .srcReq({serialOneTxReq, usartThreeRxReq, advCapTwoLow,
                 gpTimerThreeCaptureFourReq, gpTimerThreeUpdateReq, convOneFirst}),
        .chanReq(firstChanReq[2])
    );
    drr_req_or #(.WIDTH(DRR_F4_SRC)) uFirst4 (
        .srcReq({serialTwoRxReq, usartOneTxReq, twoWireTwoTxReq,
                 advTimerCaptureFourReq, advTimerTriggerReq, advTimerCommutationReq,
                 gpTimerFourCaptureTwoReq, convTwoFirst}),
        .chanReq(firstChanReq[3])
    );
    drr_req_or #(.WIDTH(DRR_F5_SRC)) uFirst5 (
        .srcReq({serialTwoTxReq, usartOneRxReq, twoWireTwoRxReq, advTimerUpdateReq,
                 gpTimerTwoCaptureOneReq, gpTimerFourCaptureThreeReq,
                 smallTimerFifteenCaptureOneReq, smallTimerFifteenUpdateReq,
                 smallTimerFifteenTriggerReq, smallTimerFifteenCommutationReq}),
        .chanReq(firstChanReq[4])
    );
    drr_req_or #(.WIDTH(DRR_F6_SRC)) uFirst6 (
        .srcReq({usartTwoRxReq, twoWireOneTxReq, advTimerCaptureThreeReq, advCapHigh,
                 gpTimerThreeCaptureOneReq, gpTimerThreeTriggerReq,
                 smallTimerSixteenCaptureOneReq, smallTimerSixteenUpdateReq, 1'b0}),
        .chanReq(firstChanReq[5])
    );
    drr_req_or #(.WIDTH(DRR_F7_SRC)) uFirst7 (
        .srcReq({usartTwoTxReq, twoWireOneRxReq, gpTimerTwoCaptureTwoReq,
                 gpTimerTwoCaptureFourReq, gpTimerFourUpdateReq,
                 smallTimerSeventeenCaptureOneReq, smallTimerSeventeenUpdateReq}),
        .chanReq(firstChanReq[6])
    );

    // Second controller channels; only five exist, so no six or seven
    drr_req_or #(.WIDTH(DRR_S1_SRC)) uSecond1 (
        .srcReq({serialThreeRxReq, fifthUartTransmitReq, timerFiveCaptureFourReq,
                 timerFiveTriggerReq}),
        .chanReq(secondRaw[0])
    );
    drr_req_or #(.WIDTH(DRR_S2_SRC)) uSecond2 (
        .srcReq({serialThreeTxReq, timerFiveCaptureThreeReq, timerFiveUpdateReq}),
        .chanReq(secondRaw[1])
    );
    drr_req_or #(.WIDTH(DRR_S3_SRC)) uSecond3 (
        .srcReq({fourthUartReceiveReq, convOneSecond}),
        .chanReq(secondRaw[2])
    );
    drr_req_or #(.WIDTH(DRR_S4_SRC)) uSecond4 (
        .srcReq({fifthUartReceiveReq, timerFiveCaptureTwoReq, convTwoSecond}),
        .chanReq(secondRaw[3])
    );
    drr_req_or #(.WIDTH(DRR_S5_SRC)) uSecond5 (
        .srcReq({fourthUartTransmitReq, timerFiveCaptureOneReq}),
        .chanReq(secondRaw[4])
    );

    // Absent controller sees no requests at all
    assign secondChanReq = hasSecond ? secondRaw : '0;

    // Register access widths belong to the controllers; nothing here decodes
    // size, so any byte, halfword or word access leaves routing untouched

    // Named steps for the relocation checks
    sequence advCaptureLive;
        advTimerCaptureOneReq || advTimerCaptureTwoReq;
    endsequence

    a_first_ch1_or: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        firstChanReq[0] == (analogConverterReq | gpTimerTwoCaptureThreeReq
                            | gpTimerFourCaptureOneReq))
        else $error("first channel 1 not the OR of its sources");
    a_adv_ch2_low: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (!advTimerRequestRelocate && advTimerCaptureOneReq) |-> firstChanReq[1])
        else $error("capture one missing on first channel 2");
    a_adv_ch3_low: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (!advTimerRequestRelocate && advTimerCaptureTwoReq) |-> firstChanReq[2])
        else $error("capture two missing on first channel 3");
    a_adv_ch6_high: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (advTimerRequestRelocate ##0 advCaptureLive) |-> firstChanReq[5])
        else $error("relocated capture missing on first channel 6");
    a_adv_not_low: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (advTimerRequestRelocate && advTimerCaptureOneReq && !serialOneRxReq
         && !usartThreeTxReq && !gpTimerTwoUpdateReq && !gpTimerThreeCaptureThreeReq)
        |-> !firstChanReq[1])
        else $error("relocated capture leaked to first channel 2");
    a_conv_steer: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        basicTimerConverterOneReq |-> (convToFirst ? firstChanReq[2] : secondChanReq[2]))
        else $error("converter one request on wrong controller");
    a_conv_two_steer: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        basicTimerConverterTwoReq |-> (convToFirst ? firstChanReq[3] : secondChanReq[3]))
        else $error("converter two request on wrong controller");
    a_second_absent: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !hasSecond |-> (secondChanReq == '0))
        else $error("second controller driven in small variant");
    a_second_ch5_or: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        hasSecond |-> (secondChanReq[4] == (fourthUartTransmitReq | timerFiveCaptureOneReq)))
        else $error("second channel 5 not the OR of its sources");
    a_same_cycle: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        $rose(analogConverterReq) |-> firstChanReq[0])
        else $error("request delayed on its way to the channel");

endmodule : dma_request_router

// ### dv/drr_periph_model.sv
// Peripheral request sources and the relocation bits of the pin function unit
module drr_periph_model (
    // Clock
    input wire logic ref_clk,
    // Request levels, index order as the bench source table
    output logic [57:0] req,
    // Relocation bits
    output logic advReloc,
    output logic convReloc
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet at time zero
    initial begin
        req = '0;
        advReloc = 1'b0;
        convReloc = 1'b0;
    end

    // Levels change at the falling edge; callers keep one source per channel
    task automatic apply(input logic [57:0] r, input logic adv, input logic conv);
        @(negedge ref_clk);
        req = r;
        advReloc = adv;
        convReloc = conv;
    endtask : apply
endmodule : drr_periph_model

// ### dv/drr_dut_wrap.sv
// Flattens the request ports onto one vector so both variants share the wiring
module drr_dut_wrap #(
    parameter drr_pkg::drr_variant_e VARIANT = drr_pkg::DRR_HIGH_DENSITY
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Sources
    input wire logic advReloc,
    input wire logic convReloc,
    input wire logic [57:0] req,
    // Channel requests
    output logic [6:0] firstChanReq,
    output logic [4:0] secondChanReq
);
    timeunit 1ns;
    timeprecision 1ps;

    dma_request_router #(.VARIANT(VARIANT)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .advTimerRequestRelocate(advReloc),
        .basicTimerConverterRelocate(convReloc), .analogConverterReq(req[0]),
        .serialOneRxReq(req[1]), .serialOneTxReq(req[2]), .serialTwoRxReq(req[3]),
        .serialTwoTxReq(req[4]), .serialThreeRxReq(req[5]), .serialThreeTxReq(req[6]),
        .usartOneTxReq(req[7]), .usartOneRxReq(req[8]), .usartTwoTxReq(req[9]),
        .usartTwoRxReq(req[10]), .usartThreeTxReq(req[11]), .usartThreeRxReq(req[12]),
        .fourthUartTransmitReq(req[13]), .fourthUartReceiveReq(req[14]),
        .fifthUartTransmitReq(req[15]), .fifthUartReceiveReq(req[16]),
        .twoWireOneTxReq(req[17]), .twoWireOneRxReq(req[18]), .twoWireTwoTxReq(req[19]),
        .twoWireTwoRxReq(req[20]), .advTimerCaptureOneReq(req[21]),
        .advTimerCaptureTwoReq(req[22]), .advTimerCaptureThreeReq(req[23]),
        .advTimerCaptureFourReq(req[24]), .advTimerTriggerReq(req[25]),
        .advTimerCommutationReq(req[26]), .advTimerUpdateReq(req[27]),
        .gpTimerTwoCaptureOneReq(req[28]), .gpTimerTwoCaptureTwoReq(req[29]),
        .gpTimerTwoCaptureThreeReq(req[30]), .gpTimerTwoCaptureFourReq(req[31]),
        .gpTimerTwoUpdateReq(req[32]), .gpTimerThreeCaptureOneReq(req[33]),
        .gpTimerThreeCaptureThreeReq(req[34]), .gpTimerThreeCaptureFourReq(req[35]),
        .gpTimerThreeUpdateReq(req[36]), .gpTimerThreeTriggerReq(req[37]),
        .gpTimerFourCaptureOneReq(req[38]), .gpTimerFourCaptureTwoReq(req[39]),
        .gpTimerFourCaptureThreeReq(req[40]), .gpTimerFourUpdateReq(req[41]),
        .timerFiveCaptureOneReq(req[42]), .timerFiveCaptureTwoReq(req[43]),
        .timerFiveCaptureThreeReq(req[44]), .timerFiveCaptureFourReq(req[45]),
        .timerFiveUpdateReq(req[46]), .timerFiveTriggerReq(req[47]),
        .basicTimerConverterOneReq(req[48]), .basicTimerConverterTwoReq(req[49]),
        .smallTimerFifteenCaptureOneReq(req[50]), .smallTimerFifteenUpdateReq(req[51]),
        .smallTimerFifteenTriggerReq(req[52]), .smallTimerFifteenCommutationReq(req[53]),
        .smallTimerSixteenCaptureOneReq(req[54]), .smallTimerSixteenUpdateReq(req[55]),
        .smallTimerSeventeenCaptureOneReq(req[56]), .smallTimerSeventeenUpdateReq(req[57]),
        .firstChanReq(firstChanReq), .secondChanReq(secondChanReq)
    );
endmodule : drr_dut_wrap

// ### dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import drr_pkg::*;

    // One nibble per source: 1..7 first channel, 9..D second channel 1..5
    localparam logic [231:0] MAP =
        232'h77_6655_55CB_9A9A_CD75_4163_3262_7175_5444_6325_476C_9BD3_2675_4A95_4321;

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [57:0] req;
    logic advReloc;
    logic convReloc;
    logic [6:0] firstHi;
    logic [6:0] firstLo;
    logic [4:0] secondHi;
    logic [4:0] secondLo;
    int nMismatch = 0;
    int checkCount = 0;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    drr_periph_model src (.ref_clk(ref_clk), .req(req), .advReloc(advReloc),
        .convReloc(convReloc));
    drr_dut_wrap #(.VARIANT(DRR_HIGH_DENSITY)) dutHi (.ref_clk(ref_clk), .rstn(rstn),
        .advReloc(advReloc), .convReloc(convReloc), .req(req), .firstChanReq(firstHi),
        .secondChanReq(secondHi));
    drr_dut_wrap #(.VARIANT(DRR_LOW_MEDIUM_DENSITY)) dutLo (.ref_clk(ref_clk), .rstn(rstn),
        .advReloc(advReloc), .convReloc(convReloc), .req(req), .firstChanReq(firstLo),
        .secondChanReq(secondLo));

    // Expected {second, first} channel requests for a source vector
    function automatic logic [11:0] expRoute(logic [57:0] r, logic adv, logic conv, logic hi);
        logic [11:0] e;
        logic [3:0] c;
        e = '0;
        for (int i = 0; i < 58; i++) begin
            c = MAP[i*4 +: 4];
            if ((i == 21 || i == 22) && adv) begin
                c = 4'h6;
            end
            if ((i == 48 || i == 49) && (conv || !hi)) begin
                c = c - 4'h8;
            end
            if (r[i] && c != 4'h0 && c < 4'h8) begin
                e[c-1] = 1'b1;
            end else if (r[i] && c > 4'h8 && hi) begin
                e[c-2] = 1'b1;
            end
        end
        return e;
    endfunction : expRoute

    task automatic cmpFirst(input string what, input logic [6:0] exp, input logic [6:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpFirst

    task automatic cmpSecond(input string what, input logic [4:0] exp, input logic [4:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpSecond

    // Looked at 1 ns after the change: no clock edge between, so no added latency
    task automatic checkNow();
        logic [11:0] h;
        logic [11:0] l;
        #1;
        h = expRoute(req, advReloc, convReloc, 1'b1);
        l = expRoute(req, advReloc, convReloc, 1'b0);
        cmpFirst("first high", h[6:0], firstHi);
        cmpSecond("second high", h[11:7], secondHi);
        cmpFirst("first low", l[6:0], firstLo);
        cmpSecond("second low", l[11:7], secondLo);
    endtask : checkNow

    // Every source alone under all four relocation settings
    task automatic testEachSource();
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 58; i++) begin
                src.apply(58'(1) << i, m[0], m[1]);
                checkNow();
            end
        end
        $display("test each source done");
    endtask : testEachSource

    // One source per channel on every channel at once, then one dropped
    task automatic testAllChannels();
        logic [57:0] v;
        v = 58'h0_0000_0000_0001_667F;
        src.apply(v, 1'b0, 1'b0);
        checkNow();
        cmpFirst("all first", 7'h7F, firstHi);
        cmpSecond("all second", 5'h1F, secondHi);
        cmpSecond("small second", 5'h00, secondLo);
        src.apply(v & ~58'h8, 1'b0, 1'b0);
        checkNow();
        cmpFirst("drop ch4", 7'h77, firstHi);
        $display("test all channels done");
    endtask : testAllChannels

    // Outputs keep following sources while reset is held
    task automatic testReset();
        @(negedge ref_clk);
        rstn = 1'b0;
        src.apply(58'h1, 1'b1, 1'b1);
        checkNow();
        @(negedge ref_clk);
        rstn = 1'b1;
        src.apply(58'h3_0000_0000_0000, 1'b1, 1'b1);
        checkNow();
        $display("test reset done");
    endtask : testReset

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : endOfTest

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(negedge ref_clk);
        testEachSource();
        testAllChannels();
        testReset();
        endOfTest();
    end

    // Watchdog, about nineteen times the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        nMismatch++;
        endOfTest();
    end
endmodule : tb
